/* File: rtl/btg_top.sv */
// beep tone generator: registers, recursive sine oscillator, per-channel volume
// Function
// - writing enable starts beep, self-clears at end
// - pen touch starts beep when auto enabled and the codec clock is present
// - left volume: +2 dB minus 1 dB per code
// - right volume uses the same encoding
// - link field selects shared or independent volume
// - beep runs only in required DAC mode
// - duration is 24-bit sample count, three bytes
// - duration resets to 238 samples
// - sine coefficient high byte, resets 0x10
// - sine coefficient low byte, resets 0xd8
// - cosine coefficient bytes reset 0x7e, 0xe3
`timescale 1ns/10ps
`include "btg_params.svh"

module btg_top
(
    // clock, enable, reset
    input  wire logic                 clk_i,
    input  wire logic                 ce_i,
    input  wire logic                 resetn_i,
    // register port
    input  wire btg_pkg::btg_reg_req_t reg_req_i,
    output logic [7:0]                rd_data_o,
    // codec context
    input  wire logic                 dac_sample_tick_i,
    input  wire logic                 dac_proc_block_twentyfive_i,
    input  wire logic                 codec_clock_input_i,
    input  wire logic                 pen_touch_i,
    // tone output
    output btg_pkg::btg_sample_t      beep_o,
    output logic                      beep_valid_o,
    output logic                      beep_busy_o
);
    import btg_pkg::*;

    btg_state_t st;
    btg_state_t next_st;

    // gain mantissa for the step inside one 6 dB octave
    function automatic logic signed [16:0] gain_mant(input logic [2:0] idx);
        logic signed [16:0] m;
        case (idx)
            3'h0:    m = `BTG_MANT_P2DB;
            3'h1:    m = `BTG_MANT_P1DB;
            3'h2:    m = `BTG_MANT_0DB;
            3'h3:    m = `BTG_MANT_M1DB;
            3'h4:    m = `BTG_MANT_M2DB;
            default: m = `BTG_MANT_M3DB;
        endcase
        return m;
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [32:0] v);
        logic signed [15:0] r;
        if (v > `BTG_SAMPLE_MAX)
        begin
            r = 16'sh7fff;
        end
        else if (v < `BTG_SAMPLE_MIN)
        begin
            r = -16'sh8000;
        end
        else
        begin
            r = v[15:0];
        end
        return r;
    endfunction

    // +2 dB at code 0, one dB lower per code: mantissa times a power-of-two shift
    function automatic logic signed [15:0] apply_gain(input logic signed [15:0] s,
                                                      input logic [5:0]         code);
        logic [5:0]         shift;
        logic [5:0]         idx;
        logic signed [32:0] prod;
        shift = code / 6'(`BTG_DB_PER_OCTAVE);
        idx   = code % 6'(`BTG_DB_PER_OCTAVE);
        prod  = 33'(s) * 33'(gain_mant(idx[2:0]));
        return sat16(prod >>> (6'(`BTG_MANT_FRAC) + shift));
    endfunction

    // effective volume code of one channel after linking
    function automatic logic [5:0] eff_vol(input logic [1:0] link,
                                           input logic [5:0] left_vol,
                                           input logic [5:0] right_vol,
                                           input logic       is_left);
        logic [5:0] v;
        // codes 00 and 11 both fall to the independent branch
        case (link)
            `BTG_LINK_L_FROM_R:
            begin
                v = right_vol;
            end
            `BTG_LINK_R_FROM_L:
            begin
                v = left_vol;
            end
            default:
            begin
                v = is_left ? left_vol : right_vol;
            end
        endcase
        return v;
    endfunction

    function automatic logic [7:0] read_mux(input btg_state_t s, input logic [6:0] addr);
        logic [7:0] d;
        case (addr)
            `BTG_OFF_LEFT:    d = s.left_ctl;
            `BTG_OFF_RIGHT:   d = s.right_ctl;
            `BTG_OFF_LEN_HI:  d = s.len_hi;
            `BTG_OFF_LEN_MID: d = s.len_mid;
            `BTG_OFF_LEN_LO:  d = s.len_lo;
            `BTG_OFF_SIN_HI:  d = s.sin_hi;
            `BTG_OFF_SIN_LO:  d = s.sin_lo;
            `BTG_OFF_COS_HI:  d = s.cos_hi;
            `BTG_OFF_COS_LO:  d = s.cos_lo;
            default:          d = 8'h00;
        endcase
        return d;
    endfunction

    // a zero count is decoded in both states
    function automatic logic is_zero_len(input logic [23:0] n);
        return (n == `BTG_ZERO_LEN);
    endfunction

    // one resonator step, cos in Q15: y[n] = 2*cos*y[n-1] - y[n-2]
    function automatic logic signed [17:0] osc_step(input logic signed [17:0] y_1,
                                                    input logic signed [17:0] y_2,
                                                    input logic signed [15:0] c);
        logic signed [33:0] p;
        p = 34'(y_1) * 34'(c);
        return 18'(p >>> `BTG_OSC_SHIFT) - y_2;
    endfunction

    // load count and seed; the first sample out is the sine coefficient itself
    function automatic btg_state_t arm(input btg_state_t         s,
                                       input logic [23:0]        n,
                                       input logic signed [15:0] c);
        btg_state_t r;
        r        = s;
        r.remain = n;
        r.y1     = 18'(c);
        r.y2     = '0;
        return r;
    endfunction

    // register file update; bit 7 of the left byte belongs to the sequencer
    function automatic btg_state_t write_regs(input btg_state_t   s,
                                              input btg_reg_req_t req);
        btg_state_t r;
        r = s;
        case (req.addr)
            `BTG_OFF_LEFT:    r.left_ctl[`BTG_AUTO_BIT:0] = req.wdata[`BTG_AUTO_BIT:0];
            `BTG_OFF_RIGHT:   r.right_ctl = req.wdata;
            `BTG_OFF_LEN_HI:  r.len_hi    = req.wdata;
            `BTG_OFF_LEN_MID: r.len_mid   = req.wdata;
            `BTG_OFF_LEN_LO:  r.len_lo    = req.wdata;
            `BTG_OFF_SIN_HI:  r.sin_hi    = req.wdata;
            `BTG_OFF_SIN_LO:  r.sin_lo    = req.wdata;
            `BTG_OFF_COS_HI:  r.cos_hi    = req.wdata;
            `BTG_OFF_COS_LO:  r.cos_lo    = req.wdata;
            default:          r           = s;
        endcase
        return r;
    endfunction

    logic               wr_left;
    logic               wr_start;
    logic               wr_stop;
    logic               touch_start;
    logic               start_req;
    logic [23:0]        length;
    logic signed [15:0] sin_coef;
    logic signed [15:0] cos_coef;
    logic signed [17:0] y0;
    logic signed [15:0] cur_sample;
    logic [5:0]         vol_l;
    logic [5:0]         vol_r;

    always_comb
    begin
        wr_left     = reg_req_i.wr && (reg_req_i.addr == `BTG_OFF_LEFT);
        wr_start    = wr_left && reg_req_i.wdata[`BTG_EN_BIT];
        wr_stop     = wr_left && !reg_req_i.wdata[`BTG_EN_BIT];
        // touch only counts while the codec clock is present
        touch_start = pen_touch_i && !st.touch_q && st.left_ctl[`BTG_AUTO_BIT]
                      && codec_clock_input_i;
        start_req   = (wr_start || touch_start) && dac_proc_block_twentyfive_i;
        length      = {st.len_hi, st.len_mid, st.len_lo};
        sin_coef    = {st.sin_hi, st.sin_lo};
        cos_coef    = {st.cos_hi, st.cos_lo};
        y0          = osc_step(st.y1, st.y2, cos_coef);
        cur_sample  = sat16(33'(st.y1));
    end

    // volumes are decoded apart from the tone path
    always_comb
    begin
        vol_l = eff_vol(st.right_ctl[`BTG_LINK_MSB:`BTG_LINK_LSB],
                        st.left_ctl[`BTG_VOL_MSB:0], st.right_ctl[`BTG_VOL_MSB:0], 1'b1);
        vol_r = eff_vol(st.right_ctl[`BTG_LINK_MSB:`BTG_LINK_LSB],
                        st.left_ctl[`BTG_VOL_MSB:0], st.right_ctl[`BTG_VOL_MSB:0], 1'b0);
    end

    always_comb
    begin
        next_st         = st;
        next_st.valid   = 1'b0;
        next_st.touch_q = pen_touch_i;
        next_st.rdata   = read_mux(st, reg_req_i.addr);

        if (reg_req_i.wr)
        begin
            next_st = write_regs(next_st, reg_req_i);
        end

        case (st.fsm)
            BTG_IDLE:
            begin
                // a zero length finishes at once, so the bit never shows set
                if (start_req && !is_zero_len(length))
                begin
                    next_st.fsm = BTG_RUN;
                    next_st     = arm(next_st, length, sin_coef);
                end
            end
            BTG_RUN:
            begin
                if (start_req)
                begin
                    // a restart wins over the self-clear in the same cycle
                    next_st = arm(next_st, is_zero_len(length) ? `BTG_ONE_LEN : length, sin_coef);
                end
                else if (wr_stop || !dac_proc_block_twentyfive_i)
                begin
                    next_st.fsm = BTG_IDLE;
                end
                else if (dac_sample_tick_i)
                begin
                    next_st.beep.left  = apply_gain(cur_sample, vol_l);
                    next_st.beep.right = apply_gain(cur_sample, vol_r);
                    next_st.valid      = 1'b1;
                    next_st.y1         = y0;
                    next_st.y2         = st.y1;
                    next_st.remain     = st.remain - `BTG_ONE_LEN;
                    if (st.remain == `BTG_ONE_LEN)
                    begin
                        next_st.fsm = BTG_IDLE;
                    end
                end
            end
            default:
            begin
                next_st.fsm = BTG_IDLE;
            end
        endcase

        // the enable bit mirrors the running state, hence it self-clears
        next_st.left_ctl[`BTG_EN_BIT] = (next_st.fsm == BTG_RUN);
        if ((next_st.fsm == BTG_IDLE) && !next_st.valid)
        begin
            // silence once the tone has ended; the closing sample still goes out
            next_st.beep = '0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            // every field back to its power-on value, coefficients included
            st.remain    <= `BTG_ZERO_LEN;
            st.y1        <= '0;
            st.y2        <= '0;
            st.beep      <= '0;
            st.valid     <= 1'b0;
            st.rdata     <= 8'h00;
            st.touch_q   <= 1'b0;
            st.fsm       <= BTG_IDLE;
            st.left_ctl  <= `BTG_RST_LEFT;
            st.right_ctl <= `BTG_RST_RIGHT;
            st.len_hi    <= `BTG_RST_LEN_HI;
            st.len_mid   <= `BTG_RST_LEN_MID;
            st.len_lo    <= `BTG_RST_LEN_LO;
            st.sin_hi    <= `BTG_RST_SIN_HI;
            st.sin_lo    <= `BTG_RST_SIN_LO;
            st.cos_hi    <= `BTG_RST_COS_HI;
            st.cos_lo    <= `BTG_RST_COS_LO;
        end
        else if (ce_i)
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        rd_data_o    = st.rdata;
        beep_o       = st.beep;
        beep_valid_o = st.valid;
        beep_busy_o  = st.left_ctl[`BTG_EN_BIT];
    end
endmodule

/* File: rtl/btg_params.svh */
// offsets, field positions, reset values and gain constants of the tone generator
`ifndef BTG_PARAMS_SVH
`define BTG_PARAMS_SVH
`define BTG_ADDR_W        7
`define BTG_OFF_LEFT      7'h47
`define BTG_OFF_RIGHT     7'h48
`define BTG_OFF_LEN_HI    7'h49
`define BTG_OFF_LEN_MID   7'h4a
`define BTG_OFF_LEN_LO    7'h4b
`define BTG_OFF_SIN_HI    7'h4c
`define BTG_OFF_SIN_LO    7'h4d
`define BTG_OFF_COS_HI    7'h4e
`define BTG_OFF_COS_LO    7'h4f
`define BTG_RST_LEFT      8'h00
`define BTG_RST_RIGHT     8'h00
`define BTG_RST_LEN_HI    8'h00
`define BTG_RST_LEN_MID   8'h00
`define BTG_RST_LEN_LO    8'hee
`define BTG_RST_SIN_HI    8'h10
`define BTG_RST_SIN_LO    8'hd8
`define BTG_RST_COS_HI    8'h7e
`define BTG_RST_COS_LO    8'he3
`define BTG_EN_BIT        7
`define BTG_AUTO_BIT      6
`define BTG_VOL_MSB       5
`define BTG_LINK_MSB      7
`define BTG_LINK_LSB      6
`define BTG_LINK_L_FROM_R 2'h1
`define BTG_LINK_R_FROM_L 2'h2
`define BTG_DB_PER_OCTAVE 6
`define BTG_MANT_FRAC     14
`define BTG_MANT_P2DB     17'h05092
`define BTG_MANT_P1DB     17'h047cf
`define BTG_MANT_0DB      17'h04000
`define BTG_MANT_M1DB     17'h0390a
`define BTG_MANT_M2DB     17'h032d6
`define BTG_MANT_M3DB     17'h02d4f
`define BTG_OSC_SHIFT     14
`define BTG_SAMPLE_MAX    33'sh000007fff
`define BTG_SAMPLE_MIN    -33'sh000008000
`define BTG_ZERO_LEN      24'h000000
`define BTG_ONE_LEN       24'h000001
`endif

/* File: rtl/btg_pkg.sv */
// types shared by the tone generator
package btg_pkg;
    typedef enum logic [1:0] {
        BTG_IDLE = 2'b01,
        BTG_RUN  = 2'b10
    } btg_fsm_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
    } btg_reg_req_t;

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } btg_sample_t;

    typedef struct packed {
        btg_fsm_t           fsm;
        logic [7:0]         left_ctl;
        logic [7:0]         right_ctl;
        logic [7:0]         len_hi;
        logic [7:0]         len_mid;
        logic [7:0]         len_lo;
        logic [7:0]         sin_hi;
        logic [7:0]         sin_lo;
        logic [7:0]         cos_hi;
        logic [7:0]         cos_lo;
        logic [23:0]        remain;
        logic signed [17:0] y1;
        logic signed [17:0] y2;
        btg_sample_t        beep;
        logic               valid;
        logic [7:0]         rdata;
        logic               touch_q;
    } btg_state_t;
endpackage

/* File: verification/btg_top_assertions.sv */
// port-level checker for the tone generator
`timescale 1ns/10ps
module btg_checker
(
    // clock and reset
    input wire logic                  clk_i,
    input wire logic                  ce_i,
    input wire logic                  resetn_i,
    // register port
    input wire btg_pkg::btg_reg_req_t reg_req_i,
    input wire logic [7:0]            rd_data_o,
    // codec context
    input wire logic                  dac_sample_tick_i,
    input wire logic                  dac_proc_block_twentyfive_i,
    input wire logic                  codec_clock_input_i,
    input wire logic                  pen_touch_i,
    // tone output
    input wire btg_pkg::btg_sample_t  beep_o,
    input wire logic                  beep_valid_o,
    input wire logic                  beep_busy_o
);
    import btg_pkg::*;
    logic touch_q;
    logic wr47;
    logic start_ok;
    logic run_tick;
    // touch edge may be over-approximated: auto bit is not tracked here
    assign wr47 = ce_i && reg_req_i.wr && reg_req_i.addr == 7'h47;
    assign start_ok = (wr47 && reg_req_i.wdata[7] || pen_touch_i && !touch_q && codec_clock_input_i)
                      && dac_proc_block_twentyfive_i;
    assign run_tick = dac_sample_tick_i && beep_busy_o;
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            touch_q <= 1'b0;
        else
            touch_q <= pen_touch_i;
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_mode_gate: assert property (!dac_proc_block_twentyfive_i && ce_i |=> !beep_busy_o)
        else $error("generator busy with mode off");
    a_start_cause: assert property ($rose(beep_busy_o) |-> $past(start_ok))
        else $error("generator started without cause");
    a_stop_write: assert property (wr47 && !reg_req_i.wdata[7] && !(pen_touch_i && !touch_q) |=> !beep_busy_o)
        else $error("zero write did not stop generator");
    a_valid_cause: assert property (beep_valid_o |-> $past(run_tick))
        else $error("sample without running tick");
    a_tick_valid: assert property (run_tick && ce_i && dac_proc_block_twentyfive_i && !reg_req_i.wr
                                   && !(pen_touch_i && !touch_q) |=> beep_valid_o)
        else $error("running tick gave no sample");
    a_idle_silent: assert property (!beep_busy_o && !beep_valid_o |-> beep_o == '0)
        else $error("output not silent while idle");
    a_busy_readback: assert property ($past(reg_req_i.addr) == 7'h47 |-> rd_data_o[7] == $past(beep_busy_o))
        else $error("enable bit does not follow running state");
    a_unmapped_zero: assert property ($past(reg_req_i.addr) < 7'h47 || $past(reg_req_i.addr) > 7'h4f
                                      |-> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind btg_top btg_checker u_chk (.clk_i(clk_i), .ce_i(ce_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i),
    .rd_data_o(rd_data_o), .dac_sample_tick_i(dac_sample_tick_i),
    .dac_proc_block_twentyfive_i(dac_proc_block_twentyfive_i), .codec_clock_input_i(codec_clock_input_i),
    .pen_touch_i(pen_touch_i), .beep_o(beep_o), .beep_valid_o(beep_valid_o), .beep_busy_o(beep_busy_o));

/* File: verification/btg_top_bench.sv */
// self-checking bench for the tone generator
`timescale 1ns/10ps
module btg_top_bench;
    import btg_pkg::*;
    logic         clk_i = 1'b0;
    logic         ce_i = 1'b1;
    logic         resetn_i = 1'b0;
    btg_reg_req_t reg_req_i = '0;
    logic [7:0]   rd_data_o;
    logic         dac_sample_tick_i = 1'b0;
    logic         dac_proc_block_twentyfive_i = 1'b1;
    logic         codec_clock_input_i = 1'b0;
    logic         pen_touch_i = 1'b0;
    btg_sample_t  beep_o;
    btg_sample_t  first_s;
    logic         beep_valid_o;
    logic         beep_busy_o;
    logic         fresh = 1'b1;
    int           n_valid = 0;
    int           n_mismatch = 0;
    int           samples_checked = 0;

    btg_top dut (.clk_i(clk_i), .ce_i(ce_i), .resetn_i(resetn_i), .reg_req_i(reg_req_i), .rd_data_o(rd_data_o),
        .dac_sample_tick_i(dac_sample_tick_i), .dac_proc_block_twentyfive_i(dac_proc_block_twentyfive_i),
        .codec_clock_input_i(codec_clock_input_i), .pen_touch_i(pen_touch_i), .beep_o(beep_o),
        .beep_valid_o(beep_valid_o), .beep_busy_o(beep_busy_o));

    always #2 clk_i = ~clk_i;

    // first sample of each run is kept for the gain checks; an idle cycle opens a new run
    always @(posedge clk_i)
    begin
        if (beep_valid_o)
        begin
            if (fresh)
                first_s <= beep_o;
            n_valid <= fresh ? 1 : n_valid + 1;
            fresh   <= 1'b0;
        end
        else if (!beep_busy_o)
        begin
            fresh <= 1'b1;
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_req_i = '{a, d, 1'b1};
        @(negedge clk_i);
        reg_req_i.wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_req_i.addr = a;
        @(negedge clk_i);
        chk("register", 16'(e), 16'(rd_data_o));
    endtask

    // tick spacing of three cycles keeps samples apart
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge clk_i);
            dac_sample_tick_i = 1'b1;
            @(negedge clk_i);
            dac_sample_tick_i = 1'b0;
            @(negedge clk_i);
        end
    endtask

    task automatic set_len(input logic [23:0] n);
        wr(7'h49, n[23:16]);
        wr(7'h4a, n[15:8]);
        wr(7'h4b, n[7:0]);
    endtask

    task automatic t_reset_values();
        logic [7:0] ev [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h10, 8'hd8, 8'h7e, 8'he3, 8'h00};
        for (int i = 0; i < 10; i++)
            rd(7'h47 + 7'(i), ev[i]);
    endtask

    // left code 2 is unity gain, right code 8 is half
    task automatic t_tone(input logic [23:0] len, input logic [1:0] lk, input logic [15:0] el, input logic [15:0] er);
        wr(7'h48, {lk, 6'h08});
        set_len(len);
        wr(7'h47, 8'h82);
        ticks(int'(len) - 1);
        rd(7'h47, 8'h82);
        ticks(1);
        rd(7'h47, 8'h02);
        chk("samples", len[15:0], 16'(n_valid));
        chk("left", el, first_s.left);
        chk("right", er, first_s.right);
    endtask

    task automatic t_guards();
        dac_proc_block_twentyfive_i = 1'b0;
        wr(7'h47, 8'h82);
        rd(7'h47, 8'h02);
        dac_proc_block_twentyfive_i = 1'b1;
        set_len(24'h000000);
        wr(7'h47, 8'h82);
        rd(7'h47, 8'h02);
        set_len(24'h000005);
        wr(7'h47, 8'h42);
        pen_touch_i = 1'b1;
        rd(7'h47, 8'h42);
        pen_touch_i = 1'b0;
        codec_clock_input_i = 1'b1;
        @(negedge clk_i);
        pen_touch_i = 1'b1;
        rd(7'h47, 8'hc2);
        dac_proc_block_twentyfive_i = 1'b0;
        rd(7'h47, 8'h42);
        dac_proc_block_twentyfive_i = 1'b1;
        pen_touch_i = 1'b0;
        wr(7'h47, 8'h82);
        wr(7'h47, 8'h02);
        rd(7'h47, 8'h02);
    endtask

    // a low enable must freeze the register file, writes included
    task automatic t_freeze();
        ce_i = 1'b0;
        wr(7'h4b, 8'h11);
        ce_i = 1'b1;
        rd(7'h4b, 8'hee);
    endtask

    // reset in the middle of a tone stops it and restores the defaults
    task automatic t_mid_reset();
        set_len(24'h000010);
        wr(7'h47, 8'h82);
        ticks(2);
        resetn_i = 1'b0;
        @(negedge clk_i);
        resetn_i = 1'b1;
        chk("busy", 16'h0000, 16'(beep_busy_o));
        rd(7'h4b, 8'hee);
        rd(7'h47, 8'h00);
    endtask

    task automatic t_writes();
        for (int i = 1; i < 9; i++)
        begin
            wr(7'h47 + 7'(i), 8'h5a + 8'(i));
            rd(7'h47 + 7'(i), 8'h5a + 8'(i));
        end
        wr(7'h50, 8'hff);
        rd(7'h50, 8'h00);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        t_reset_values();
        t_freeze();
        t_tone(24'h000103, 2'b00, 16'h10d8, 16'h086c);
        t_tone(24'h000001, 2'b01, 16'h086c, 16'h086c);
        t_tone(24'h000001, 2'b10, 16'h10d8, 16'h10d8);
        t_tone(24'h000001, 2'b11, 16'h10d8, 16'h086c);
        t_guards();
        t_writes();
        t_mid_reset();
        finish_test();
    end

    // a hang counts as a mismatch
    initial
    begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule
